// [hw/sdbrw_pkg.sv]
/*
 * Shared constants of the burst read/write block: register map, field
 * positions, reset values, burst modes and cycle counts.
 * Assumes: included before every other file of the block.
 */
package sdbrw_pkg;
   // --------------------------------------------------
   // Register offsets
   // --------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_LAT = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;
   localparam logic [7:0] REG_RDCNT = 8'h0C;
   localparam logic [7:0] REG_WRCNT = 8'h10;
   localparam logic [7:0] REG_ERRCNT = 8'h14;

   // --------------------------------------------------
   // Field positions and reset values
   // --------------------------------------------------
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_DLL_BIT = 2;
   localparam int LAT_CL_LSB = 0;
   localparam int LAT_AL_LSB = 5;
   localparam int LAT_CWL_LSB = 10;
   localparam int STAT_LOCK_BIT = 0;
   localparam int STAT_OPEN_LSB = 1;
   localparam int STAT_CCD_BIT = 9;
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [14:0] LAT_RST = 15'h1406;

   // --------------------------------------------------
   // Burst length field encodings
   // --------------------------------------------------
   localparam logic [1:0] MODE_BL8 = 2'h0;
   localparam logic [1:0] MODE_OTF = 2'h1;

   // --------------------------------------------------
   // Command address bits
   // --------------------------------------------------
   localparam int ADDR_BC_BIT = 12;
   localparam int ADDR_AP_BIT = 10;
   localparam int ADDR_NIB_BIT = 2;
   localparam int ADDR_COL_LSB = 3;

   // --------------------------------------------------
   // Cycle counts, link clock
   // --------------------------------------------------
   localparam logic [2:0] CCD_CYC = 3'h4;
   localparam logic [1:0] BL8_LAST_BEAT = 2'h3;
   localparam logic [1:0] BC4_LAST_BEAT = 2'h1;
   localparam logic [9:0] DLL_LOCK_CYC = 10'h200;
   localparam int QDEPTH = 32;

   typedef enum logic [1:0] {SDBRW_IDLE, SDBRW_RD, SDBRW_WR} sdbrw_burst_t;
endpackage

// [hw/sdbrw_evt_if.sv]
/*
 * Carrier for one-cycle events passed from the link domain to the
 * system domain.
 * Assumes: source pulses are one link cycle long and sparse.
 */
`timescale 1ns/1ns
interface sdbrw_evt_if;
   logic [3:0] evt_src;
   logic [3:0] evt_dst;
   modport user (output evt_src, input evt_dst);
   modport xfer (input evt_src, output evt_dst);
endinterface

// [hw/sdbrw_sync2.sv]
/*
 * Two flip-flop level synchroniser.
 * Assumes: each bit is an independent level; words are not coherent.
 */
`timescale 1ns/1ns
module sdbrw_sync2 #(
   parameter int W = 1
) (
   // Destination clock
   input logic clk,
   input logic rst_n,
   // Levels
   input logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sdbrw_sync_t;
   sdbrw_sync_t st_r;
   sdbrw_sync_t st_nxt;

   always_comb begin
      st_nxt.s1 = din;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign dout = st_r.s2;
endmodule

// [hw/sdbrw_pulse_xfer.sv]
/*
 * Toggle based event crossing, four events wide.
 * Assumes: events on one bit are spaced by more than three
 * destination cycles, else some merge.
 */
`timescale 1ns/1ns
module sdbrw_pulse_xfer (
   // Source domain
   input logic clk_src,
   input logic rst_src_n,
   // Destination domain
   input logic clk_dst,
   input logic rst_dst_n,
   // Events
   sdbrw_evt_if.xfer evt
);
   logic [3:0] tgl_r;
   logic [3:0] tgl_nxt;
   logic [3:0] tgl_sync;
   logic [3:0] seen_r;
   logic [3:0] seen_nxt;

   always_comb begin
      tgl_nxt = tgl_r ^ evt.evt_src;
      seen_nxt = tgl_sync;
   end

   always_ff @(posedge clk_src or negedge rst_src_n) begin
      if (!rst_src_n) begin
         tgl_r <= '0;
      end else begin
         tgl_r <= tgl_nxt;
      end
   end

   sdbrw_sync2 #(.W(4)) u_sync (
      .clk(clk_dst),
      .rst_n(rst_dst_n),
      .din(tgl_r),
      .dout(tgl_sync)
   );

   always_ff @(posedge clk_dst or negedge rst_dst_n) begin
      if (!rst_dst_n) begin
         seen_r <= '0;
      end else begin
         seen_r <= seen_nxt;
      end
   end

   assign evt.evt_dst = tgl_sync ^ seen_r;
endmodule

// [hw/sdbrw_top.sv]
/*
 * Burst read/write engine of a DDR-style memory device, with a small
 * storage array, latency pipeline, bank open tracking and a register
 * port in the system clock domain.
 * Assumes: commands and write data are synchronous to ck; two data
 * beats per ck cycle travel as one 16-bit word, low byte first.
 */
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
module sdbrw_top (
   // System clock and reset
   input logic clk_sys,
   input logic rst_n,
   // Register port
   input logic [7:0] reg_addr,
   input logic [31:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   output logic [31:0] reg_rdata,
   // Link clock and command pins
   input logic ck,
   input logic cs_n,
   input logic ras_n,
   input logic cas_n,
   input logic we_n,
   input logic [2:0] ba,
   input logic [13:0] addr,
   // Data and strobe pins
   input logic [15:0] dq_rx,
   output logic [15:0] dq_tx,
   output logic dq_tx_en,
   output logic [1:0] dqs_tx,
   output logic dqs_tx_en,
   input logic wr_strobe_err,
   // Link status
   output logic rd_timing_ok
);
   // --------------------------------------------------
   // Types
   // --------------------------------------------------
   localparam int QDEPTH_W = sdbrw_pkg::QDEPTH;
   typedef struct packed {
      logic vld;
      logic wr;
      logic bl8;
      logic ap;
      logic [2:0] bank;
      logic [2:0] colg;
      logic nib;
   } sdbrw_slot_t;

   typedef struct packed {
      sdbrw_slot_t [QDEPTH_W-1:0] q;
      sdbrw_pkg::sdbrw_burst_t st;
      sdbrw_slot_t cur;
      logic [1:0] beat;
      logic burst_err;
      logic [7:0] open_bank;
      logic [2:0] ccd;
      logic [9:0] lock_cnt;
      logic locked;
      logic cfg_seen;
      logic [2:0] ctrl;
      logic [14:0] lat;
      logic [15:0] dq;
      logic dq_en;
      logic [3:0] ev;
   } sdbrw_lnk_t;

   typedef struct packed {
      logic [2:0] ctrl;
      logic [14:0] lat;
      logic cfg_tgl;
      logic ccd_sticky;
      logic [15:0] rdcnt;
      logic [15:0] wrcnt;
      logic [15:0] errcnt;
      logic [31:0] rdata;
   } sdbrw_core_t;

   // --------------------------------------------------
   // Functions
   // --------------------------------------------------
   // Queue slot for a latency, with launch offset; clamped into range
   function automatic logic [4:0] slot_pos(input logic [5:0] lat, input logic [5:0] off);
      logic [5:0] p;
      p = (lat > off) ? lat - off : 6'h00;
      slot_pos = (p > 6'h1F) ? 5'h1F : p[4:0];
   endfunction

   // Array index of one beat of a burst
   function automatic logic [8:0] word_addr(input sdbrw_slot_t s, input logic [1:0] b, input logic hi);
      logic [2:0] w;
      w = {s.nib & ~s.bl8, 2'h0} + {b, hi};
      word_addr = {s.bank, s.colg, w};
   endfunction

   // --------------------------------------------------
   // Reset release, one copy per domain
   // --------------------------------------------------
   logic [1:0] rst_sys_r;
   logic [1:0] rst_lnk_r;
   logic rst_sys_n;
   logic rst_lnk_n;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_sys_r <= 2'h0;
      end else begin
         rst_sys_r <= {rst_sys_r[0], 1'b1};
      end
   end

   always_ff @(posedge ck or negedge rst_n) begin
      if (!rst_n) begin
         rst_lnk_r <= 2'h0;
      end else begin
         rst_lnk_r <= {rst_lnk_r[0], 1'b1};
      end
   end

   assign rst_sys_n = rst_sys_r[1];
   assign rst_lnk_n = rst_lnk_r[1];

   // --------------------------------------------------
   // Crossings
   // --------------------------------------------------
   sdbrw_core_t c_r;
   sdbrw_core_t c_nxt;
   sdbrw_lnk_t l_r;
   sdbrw_lnk_t l_nxt;
   logic cfg_tgl_sync;
   logic [8:0] stat_sync;
   sdbrw_evt_if evt ();

   // Config words are held still while the toggle travels
   sdbrw_sync2 #(.W(1)) u_cfg_sync (
      .clk(ck),
      .rst_n(rst_lnk_n),
      .din(c_r.cfg_tgl),
      .dout(cfg_tgl_sync)
   );

   // Bank bits cross as independent levels, not as one word
   sdbrw_sync2 #(.W(9)) u_stat_sync (
      .clk(clk_sys),
      .rst_n(rst_sys_n),
      .din({l_r.open_bank, l_r.locked}),
      .dout(stat_sync)
   );

   sdbrw_pulse_xfer u_evt (
      .clk_src(ck),
      .rst_src_n(rst_lnk_n),
      .clk_dst(clk_sys),
      .rst_dst_n(rst_sys_n),
      .evt(evt.xfer)
   );

   assign evt.evt_src = l_r.ev;

   // --------------------------------------------------
   // Storage array, link domain
   // --------------------------------------------------
   logic [7:0] mem [0:511];
   logic mem_we;
   logic [8:0] mem_wa0;
   logic [8:0] mem_wa1;

   always_ff @(posedge ck) begin
      if (mem_we) begin
         mem[mem_wa0] <= dq_rx[7:0];
         mem[mem_wa1] <= dq_rx[15:8];
      end
   end

   // --------------------------------------------------
   // Link domain: commands, latency queue, burst engine
   // --------------------------------------------------
   always_comb begin
      sdbrw_slot_t act;
      logic go;
      logic [1:0] b;
      logic [1:0] last;
      logic err_acc;
      logic is_col;
      logic [4:0] pos;
      logic [5:0] rl;
      logic [5:0] wl;
      act = '0;
      go = 1'b0;
      b = 2'h0;
      last = 2'h0;
      err_acc = 1'b0;
      pos = 5'h00;
      l_nxt = l_r;
      l_nxt.ev = 4'h0;
      l_nxt.dq_en = 1'b0;
      mem_we = 1'b0;
      mem_wa0 = 9'h000;
      mem_wa1 = 9'h000;
      if (cfg_tgl_sync != l_r.cfg_seen) begin
         l_nxt.cfg_seen = cfg_tgl_sync;
         l_nxt.ctrl = c_r.ctrl;
         l_nxt.lat = c_r.lat;
      end
      if (!l_r.ctrl[sdbrw_pkg::CTRL_DLL_BIT]) begin
         l_nxt.lock_cnt = 10'h000;
         l_nxt.locked = 1'b0;
      end else if (!l_r.locked) begin
         l_nxt.lock_cnt = l_r.lock_cnt + 10'h001;
         l_nxt.locked = (l_r.lock_cnt == sdbrw_pkg::DLL_LOCK_CYC - 10'h001);
      end
      if (l_r.ccd != 3'h0) begin
         l_nxt.ccd = l_r.ccd - 3'h1;
      end
      for (int i = 0; i < QDEPTH_W - 1; i++) begin
         l_nxt.q[i] = l_r.q[i+1];
      end
      l_nxt.q[QDEPTH_W-1] = '0;
      rl = {1'b0, l_r.lat[sdbrw_pkg::LAT_AL_LSB +: 5]} + {1'b0, l_r.lat[sdbrw_pkg::LAT_CL_LSB +: 5]};
      wl = {1'b0, l_r.lat[sdbrw_pkg::LAT_AL_LSB +: 5]} + {1'b0, l_r.lat[sdbrw_pkg::LAT_CWL_LSB +: 5]};
      if (!cs_n && !ras_n && cas_n && we_n) begin
         l_nxt.open_bank[ba] = 1'b1;
      end
      if (!cs_n && !ras_n && cas_n && !we_n) begin
         if (addr[sdbrw_pkg::ADDR_AP_BIT]) begin
            l_nxt.open_bank = 8'h00;
         end else begin
            l_nxt.open_bank[ba] = 1'b0;
         end
      end
      is_col = !cs_n && ras_n && !cas_n;
      if (is_col) begin
         if (l_r.ccd != 3'h0) begin
            l_nxt.ev[3] = 1'b1; // Too close: command dropped
         end else begin
            act.vld = 1'b1;
            act.wr = !we_n;
            act.bl8 = (l_r.ctrl[1:0] == sdbrw_pkg::MODE_BL8) ||
                      ((l_r.ctrl[1:0] == sdbrw_pkg::MODE_OTF) && addr[sdbrw_pkg::ADDR_BC_BIT]);
            act.ap = addr[sdbrw_pkg::ADDR_AP_BIT];
            act.bank = ba;
            act.colg = addr[sdbrw_pkg::ADDR_COL_LSB +: 3]; // A12 kept out of the column
            act.nib = addr[sdbrw_pkg::ADDR_NIB_BIT];
            // Read launches one cycle early since output is registered
            pos = we_n ? slot_pos(rl, 6'h02) : slot_pos(wl, 6'h01);
            l_nxt.q[pos] = act;
            l_nxt.ccd = sdbrw_pkg::CCD_CYC - 3'h1;
         end
      end
      if (l_r.q[0].vld) begin
         act = l_r.q[0];
         go = 1'b1;
      end else if (l_r.st != sdbrw_pkg::SDBRW_IDLE) begin
         act = l_r.cur;
         b = l_r.beat;
         go = 1'b1;
      end
      if (go) begin
         last = act.bl8 ? sdbrw_pkg::BL8_LAST_BEAT : sdbrw_pkg::BC4_LAST_BEAT;
         if (act.wr) begin
            mem_we = 1'b1;
            mem_wa0 = word_addr(act, b, 1'b0);
            mem_wa1 = word_addr(act, b, 1'b1);
            // Bad strobe only taints this burst's words
            err_acc = ((b != 2'h0) && l_r.burst_err) || wr_strobe_err;
         end else begin
            l_nxt.dq = {mem[word_addr(act, b, 1'b1)], mem[word_addr(act, b, 1'b0)]};
            l_nxt.dq_en = 1'b1;
         end
         // Beat count or a newly due queue slot ends a burst, so strobes can never stall it
         if (b == last) begin
            l_nxt.st = sdbrw_pkg::SDBRW_IDLE;
            l_nxt.beat = 2'h0;
            l_nxt.burst_err = 1'b0;
            l_nxt.ev[0] = !act.wr;
            l_nxt.ev[1] = act.wr;
            l_nxt.ev[2] = act.wr && err_acc;
            if (act.ap) begin
               l_nxt.open_bank[act.bank] = 1'b0;
            end
         end else begin
            l_nxt.st = act.wr ? sdbrw_pkg::SDBRW_WR : sdbrw_pkg::SDBRW_RD;
            l_nxt.cur = act;
            l_nxt.beat = b + 2'h1;
            l_nxt.burst_err = err_acc;
         end
      end
   end

   always_ff @(posedge ck or negedge rst_lnk_n) begin
      if (!rst_lnk_n) begin
         l_r <= '0;
         l_r.st <= sdbrw_pkg::SDBRW_IDLE;
         l_r.ctrl <= sdbrw_pkg::CTRL_RST;
         l_r.lat <= sdbrw_pkg::LAT_RST;
      end else begin
         l_r <= l_nxt;
      end
   end

   assign dq_tx = l_r.dq;
   assign dq_tx_en = l_r.dq_en;
   assign dqs_tx = l_r.dq_en ? 2'h1 : 2'h0;
   assign dqs_tx_en = l_r.dq_en;
   // Strobe edges are only trusted with a locked loop
   assign rd_timing_ok = l_r.locked;

   // --------------------------------------------------
   // System domain: register port and counters
   // --------------------------------------------------
   always_comb begin
      c_nxt = c_r;
      c_nxt.rdata = 32'h0000_0000;
      if (reg_wr) begin
         case (reg_addr)
            sdbrw_pkg::REG_CTRL: begin
               c_nxt.ctrl = reg_wdata[2:0];
               c_nxt.cfg_tgl = ~c_r.cfg_tgl;
            end
            sdbrw_pkg::REG_LAT: begin
               c_nxt.lat = reg_wdata[14:0];
               c_nxt.cfg_tgl = ~c_r.cfg_tgl;
            end
            sdbrw_pkg::REG_STAT: begin
               if (reg_wdata[sdbrw_pkg::STAT_CCD_BIT]) begin
                  c_nxt.ccd_sticky = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      // Applied after the clear so a same-cycle event wins
      if (evt.evt_dst[3]) begin
         c_nxt.ccd_sticky = 1'b1;
      end
      c_nxt.rdcnt = c_r.rdcnt + {15'h0000, evt.evt_dst[0]};
      c_nxt.wrcnt = c_r.wrcnt + {15'h0000, evt.evt_dst[1]};
      c_nxt.errcnt = c_r.errcnt + {15'h0000, evt.evt_dst[2]};
      if (reg_rd) begin
         case (reg_addr)
            sdbrw_pkg::REG_CTRL: c_nxt.rdata = {29'h0000_0000, c_r.ctrl};
            sdbrw_pkg::REG_LAT: c_nxt.rdata = {17'h0_0000, c_r.lat};
            sdbrw_pkg::REG_STAT: c_nxt.rdata = {22'h00_0000, c_r.ccd_sticky, stat_sync};
            sdbrw_pkg::REG_RDCNT: c_nxt.rdata = {16'h0000, c_r.rdcnt};
            sdbrw_pkg::REG_WRCNT: c_nxt.rdata = {16'h0000, c_r.wrcnt};
            sdbrw_pkg::REG_ERRCNT: c_nxt.rdata = {16'h0000, c_r.errcnt};
            default: c_nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_sys_n) begin
      if (!rst_sys_n) begin
         c_r <= '0;
         c_r.ctrl <= sdbrw_pkg::CTRL_RST;
         c_r.lat <= sdbrw_pkg::LAT_RST;
      end else begin
         c_r <= c_nxt;
      end
   end

   assign reg_rdata = c_r.rdata;
endmodule

// [test/sdbrw_monitor.sv]
/* Checker of the burst engine, watching the top ports only.
   Assumes reset latencies (read latency 6). */
`timescale 1ns/1ns
module sdbrw_monitor (
   // System side
   input logic clk_sys,
   input logic rst_n,
   input logic [7:0] reg_addr,
   input logic [31:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   input logic [31:0] reg_rdata,
   // Link side
   input logic ck,
   input logic cs_n,
   input logic ras_n,
   input logic cas_n,
   input logic we_n,
   input logic [13:0] addr,
   input logic dq_tx_en,
   input logic [1:0] dqs_tx,
   input logic dqs_tx_en,
   input logic rd_timing_ok
);
   // ------
   // Shadow state
   // ------
   logic [1:0] mode_r;
   logic dll_r;
   logic [2:0] gap_r;
   logic [9:0] lock_r;
   wire col = !cs_n && ras_n && !cas_n;
   wire rd_acc = col && we_n && (gap_r >= 3'h4);
   wire bl8 = (mode_r == 2'h0) || ((mode_r == 2'h1) && addr[12]);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= 2'h0;
         dll_r <= 1'b0;
      end else if (reg_wr && reg_addr == sdbrw_pkg::REG_CTRL) begin
         mode_r <= reg_wdata[1:0];
         dll_r <= reg_wdata[2];
      end
   end
   // Runs ahead of the design's synchronised copy
   always_ff @(posedge ck or negedge rst_n) begin
      if (!rst_n) begin
         gap_r <= 3'h7;
         lock_r <= 10'h0;
      end else begin
         gap_r <= (col && gap_r >= 3'h4) ? 3'h1 : ((gap_r == 3'h7) ? gap_r : gap_r + 3'h1);
         lock_r <= !dll_r ? 10'h0 : ((lock_r == 10'h3FF) ? lock_r : lock_r + 10'h1);
      end
   end
   // ------
   // Assertions
   // ------
   a_strobe_pair: assert property (@(posedge ck) disable iff (!rst_n) dqs_tx_en == dq_tx_en)
      else $error("strobe enable differs");
   a_strobe_shape: assert property (@(posedge ck) disable iff (!rst_n) dqs_tx == (dq_tx_en ? 2'h1 : 2'h0))
      else $error("strobe pattern wrong");
   a_read_latency: assert property (@(posedge ck) disable iff (!rst_n) rd_acc |-> ##6 dq_tx_en)
      else $error("read data late");
   a_eight_beats: assert property (@(posedge ck) disable iff (!rst_n) rd_acc && bl8 |-> ##6 dq_tx_en [*4])
      else $error("long burst cut short");
   a_chop_beats: assert property (@(posedge ck) disable iff (!rst_n)
      rd_acc && !bl8 |-> ##6 dq_tx_en [*2] ##1 !dq_tx_en) else $error("chop length wrong");
   a_no_spurious: assert property (@(posedge ck) disable iff (!rst_n) $rose(dq_tx_en) |-> $past(rd_acc, 6))
      else $error("read data without read");
   a_lock_wait: assert property (@(posedge ck) disable iff (!rst_n) $rose(rd_timing_ok) |-> lock_r >= 10'h200)
      else $error("flag before lock");
   a_mode_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
      reg_rd && reg_addr == sdbrw_pkg::REG_CTRL |=> reg_rdata[1:0] == $past(mode_r)) else $error("mode readback wrong");
   a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      reg_rd && reg_addr > sdbrw_pkg::REG_ERRCNT |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
   c_long_read: cover property (@(posedge ck) rd_acc && bl8);
   c_chop_read: cover property (@(posedge ck) rd_acc && !bl8);
   c_refused: cover property (@(posedge ck) col && we_n && !rd_acc);
endmodule

bind sdbrw_top sdbrw_monitor u_mon (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
   .we_n(we_n), .addr(addr), .dq_tx_en(dq_tx_en), .dqs_tx(dqs_tx), .dqs_tx_en(dqs_tx_en), .rd_timing_ok(rd_timing_ok));

// [test/sdbrw_ctrl_model.sv]
/* Memory controller model: commands, write data and bank timing.
   Assumes reset latencies, so write latency is 5. */
`timescale 1ns/1ns
module sdbrw_ctrl_model (
   // Link clock
   input logic ck,
   // Command pins
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [2:0] ba,
   output logic [13:0] addr,
   // Write data
   output logic [15:0] dq_rx,
   output logic wr_strobe_err
);
   // 7.5 ns is under one 30 ns cycle, so four cycles dominate
   localparam int T_RTP = 4;
   localparam int T_RAS = 12, T_RP = 4, T_RC = 16, T_WR = 8;
   int cyc = 0;
   int t_act[8] = '{default: -100}, t_pre[8] = '{default: -100}, t_done[8] = '{default: -100};
   initial begin
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
      {ba, addr, dq_rx, wr_strobe_err} = 34'h0;
   end
   always @(posedge ck) cyc <= cyc + 1;
   // Bank spacings are kept, so no reset is owed; column gaps are left to the caller
   task automatic wait_to(input int t);
      while (cyc < t) @(posedge ck);
   endtask
   task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
      @(posedge ck);
      {cs_n, ras_n, cas_n, we_n} <= c;
      ba <= b;
      addr <= a;
      @(posedge ck);
      {cs_n, ras_n, cas_n, we_n} <= 4'hF;
      // Released lines must not echo the last command
      ba <= ~b;
      addr <= ~a;
   endtask
   task automatic activate(input logic [2:0] b);
      wait_to(t_pre[b] + T_RP);
      wait_to(t_act[b] + T_RC);
      issue(4'h3, b, 14'h0);
      t_act[b] = cyc;
      repeat (4) @(posedge ck);
   endtask
   task automatic precharge(input logic [2:0] b);
      wait_to(t_act[b] + T_RAS);
      wait_to(t_done[b]);
      issue(4'h2, b, 14'h0);
      t_pre[b] = cyc;
   endtask
   task automatic read_cmd(input logic [2:0] b, input logic [13:0] a, input int gap);
      repeat (gap) @(posedge ck);
      issue(4'h5, b, a);
      t_done[b] = cyc + T_RTP;
      if (a[10]) t_pre[b] = t_done[b];
   endtask
   task automatic write_burst(input logic [2:0] b, input logic [13:0] a, input logic [63:0] w, input int pairs,
      input int bad);
      repeat (2) @(posedge ck);
      issue(4'h4, b, a);
      repeat (4) @(posedge ck);
      for (int i = 0; i < pairs; i++) begin
         dq_rx <= w[i*16 +: 16];
         wr_strobe_err <= (i == bad);
         @(posedge ck);
      end
      dq_rx <= ~w[(pairs-1)*16 +: 16];
      wr_strobe_err <= 1'b0;
      t_done[b] = cyc + T_WR;
      if (a[10]) t_pre[b] = t_done[b];
   endtask
endmodule

// [test/tb_top.sv]
/* Top bench: register tasks, read capture, reference memory.
   Assumes the model drives all link inputs. */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
   logic clk_sys = 1'b0;
   logic ck = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata, d;
   logic cs_n, ras_n, cas_n, we_n, dq_tx_en, dqs_tx_en, wr_strobe_err, rd_timing_ok, nib;
   logic [2:0] ba, b, c;
   logic [13:0] addr;
   logic [15:0] dq_rx, dq_tx;
   logic [1:0] dqs_tx;
   logic [1:0] mode = 2'h0;
   logic [7:0] open_m = 8'h00;
   logic [7:0] mem[int];
   logic [7:0] exp_q[$], got_q[$];
   int n_errors = 0;
   int total_checks = 0;
   int seed = 32'hf875e147;
   int cycles = 0, n_rd = 0, n_wr = 0, n_bad = 0;
   always #25 clk_sys = ~clk_sys;
   always #15 ck = ~ck;
   sdbrw_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .ba(ba), .addr(addr), .dq_rx(dq_rx), .dq_tx(dq_tx), .dq_tx_en(dq_tx_en), .dqs_tx(dqs_tx),
      .dqs_tx_en(dqs_tx_en), .wr_strobe_err(wr_strobe_err), .rd_timing_ok(rd_timing_ok));
   sdbrw_ctrl_model u_ctl (.ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
      .dq_rx(dq_rx), .wr_strobe_err(wr_strobe_err));
   always @(posedge ck) if (dq_tx_en === 1'b1) begin
      got_q.push_back(dq_tx[7:0]);
      got_q.push_back(dq_tx[15:8]);
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 30000) begin
         n_errors++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic set_mode(input logic [1:0] m);
      mode = m;
      reg_write(sdbrw_pkg::REG_CTRL, {29'h0, 1'b1, m});
      repeat (4) @(posedge clk_sys);
   endtask
   function automatic logic [13:0] col_addr(input logic [2:0] cg, input logic a12, input logic nb, input logic ap);
      col_addr = {1'b0, a12, 1'b0, ap, 4'h0, cg, nb, 2'h0};
   endfunction
   function automatic logic is_bl8(input logic a12);
      is_bl8 = (mode == 2'h0) || (mode == 2'h1 && a12);
   endfunction
   task automatic wr_burst(input logic [2:0] bk, input logic [2:0] cg, input logic a12, input logic nb, input int bad);
      logic [63:0] w;
      int n, base;
      w = {$random(seed), $random(seed)};
      n = is_bl8(a12) ? 8 : 4;
      base = is_bl8(a12) ? 0 : nb * 4;
      for (int i = 0; i < n; i++) mem[bk * 64 + cg * 8 + base + i] = w[i*8 +: 8];
      n_wr++;
      if (bad >= 0) n_bad++;
      u_ctl.write_burst(bk, col_addr(cg, a12, nb, 1'b0), w, n / 2, bad);
   endtask
   task automatic rd_burst(input logic [2:0] bk, input logic [2:0] cg, input logic a12, input logic nb,
      input logic ap, input int gap, input logic kept);
      int n, base;
      n = is_bl8(a12) ? 8 : 4;
      base = is_bl8(a12) ? 0 : nb * 4;
      if (kept) begin
         n_rd++;
         for (int i = 0; i < n; i++) exp_q.push_back(mem[bk * 64 + cg * 8 + base + i]);
         if (ap) open_m[bk] = 1'b0;
      end
      u_ctl.read_cmd(bk, col_addr(cg, a12, nb, ap), gap);
   endtask
   task automatic check_reads();
      repeat (60) if (got_q.size() < exp_q.size()) @(posedge ck);
      repeat (6) @(posedge ck);
      `CHK("read beats", exp_q.size(), got_q.size())
      for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) `CHK("read byte", exp_q[i], got_q[i])
      exp_q.delete();
      got_q.delete();
   endtask
   task automatic check_open();
      repeat (8) @(posedge clk_sys);
      reg_read(sdbrw_pkg::REG_STAT);
      `CHK("open banks", open_m, d[8:1])
   endtask
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      reg_read(sdbrw_pkg::REG_CTRL);
      `CHK("ctrl reset", {29'h0, sdbrw_pkg::CTRL_RST}, d)
      reg_read(sdbrw_pkg::REG_LAT);
      `CHK("lat reset", {17'h0, sdbrw_pkg::LAT_RST}, d)
      reg_write(8'h1C, $random(seed));
      reg_read(8'h1C);
      `CHK("unmapped", 32'h0, d)
      `CHK("timing flag off", 1'b0, rd_timing_ok)
      for (int m = 0; m < 4; m++) begin
         for (int k = 0; k < 2; k++) begin
            b = 3'($random(seed));
            c = 3'($random(seed));
            nib = 1'($random(seed));
            set_mode(2'h0);
            u_ctl.activate(b);
            open_m[b] = 1'b1;
            wr_burst(b, c, 1'b1, 1'b0, -1);
            set_mode(2'(m));
            wr_burst(b, c, 1'(k), nib, (m == 3 && k == 1) ? 0 : -1);
            rd_burst(b, c, 1'(k), nib, 1'(k), 2, 1'b1);
            check_reads();
            if (k == 0) begin
               u_ctl.precharge(b);
               open_m[b] = 1'b0;
            end
            check_open();
         end
      end
      set_mode(2'h1);
      u_ctl.activate(3'h5);
      open_m[5] = 1'b1;
      wr_burst(3'h5, 3'h2, 1'b1, 1'b0, -1);
      rd_burst(3'h5, 3'h2, 1'b0, 1'b1, 1'b0, 2, 1'b1);
      rd_burst(3'h5, 3'h2, 1'b1, 1'b0, 1'b0, 2, 1'b1);
      rd_burst(3'h5, 3'h2, 1'b1, 1'b0, 1'b0, 1, 1'b0);
      check_reads();
      check_open();
      `CHK("spacing flag", 1'b1, d[9])
      reg_write(sdbrw_pkg::REG_STAT, 32'h200);
      reg_read(sdbrw_pkg::REG_STAT);
      `CHK("spacing clear", 1'b0, d[9])
      u_ctl.precharge(3'h5);
      repeat (8) @(posedge clk_sys);
      reg_read(sdbrw_pkg::REG_RDCNT);
      `CHK("read count", 16'(n_rd), d[15:0])
      reg_read(sdbrw_pkg::REG_WRCNT);
      `CHK("write count", 16'(n_wr), d[15:0])
      reg_read(sdbrw_pkg::REG_ERRCNT);
      `CHK("error count", 16'(n_bad), d[15:0])
      repeat (700) if (rd_timing_ok !== 1'b1) @(posedge ck);
      `CHK("timing flag on", 1'b1, rd_timing_ok)
      complete_run();
   end
endmodule
